// ### logic/psl_regs.svh
// Register offsets, field positions, reset values and codes of the precise sampling block.
`ifndef PSL_REGS_SVH
`define PSL_REGS_SVH

`define PSL_OFF_EVSEL 8'h00
`define PSL_OFF_CTR 8'h20
`define PSL_OFF_RELOAD 8'h40
`define PSL_OFF_SEN_LO 8'h50
`define PSL_OFF_SEN_HI 8'h54
`define PSL_OFF_THRESH 8'h58
`define PSL_OFF_STAT_LO 8'h5C
`define PSL_OFF_STAT_HI 8'h60
`define PSL_OFF_CLR_LO 8'h64
`define PSL_OFF_CLR_HI 8'h68
`define PSL_OFF_BUF_IDX 8'h6C
`define PSL_OFF_BUF_LIM 8'h70
`define PSL_OFF_REC_ADDR 8'h74
`define PSL_OFF_REC_SRC 8'h78
`define PSL_OFF_REC_LAT 8'h7C
`define PSL_OFF_REC_IP 8'h80

`define PSL_EVSEL_EN_BIT 22
`define PSL_STORE_CAP_BIT 31
`define PSL_BUF_FULL_BIT 30
`define PSL_LAT_EVSEL 16'h01CD
`define PSL_STORE_EVSEL 16'h02CD
`define PSL_EXACT_DIST_EVSEL 16'h01C0
`define PSL_EXACT_DIST_CTR 3'h1
`define PSL_STORE_CTR 3'h3
`define PSL_THRESH_RST 16'h0003
`define PSL_LFSR_SEED 16'hACE1

`endif

// ### logic/psl_pkg.sv
// Types shared by the precise sampling block.
package psl_pkg;

   typedef enum logic [1:0] {S_IDLE, S_SKID, S_WRITE} psl_state_e;

   typedef struct packed {
      logic valid;
      logic [7:0] code;
      logic [7:0] umask;
      logic [31:0] ip;
      logic fused;
   } psl_retire_s;

   typedef struct packed {
      logic dispatch;
      logic [3:0] disp_id;
      logic cancel;
      logic [3:0] cancel_id;
      logic writeback;
      logic [3:0] wb_id;
      logic retire;
      logic [3:0] ret_id;
      logic demand;
      logic [31:0] addr;
      logic [3:0] src;
      logic second_level_translation_miss;
      logic lock;
   } psl_load_s;

   typedef struct packed {
      logic retire;
      logic [31:0] addr;
      logic l1_hit;
      logic second_level_translation_miss;
      logic lock;
   } psl_store_s;

   typedef struct packed {
      logic [31:0] addr;
      logic [5:0] src;
      logic [15:0] lat;
      logic [31:0] ip;
      logic [1:0] ctr;
   } psl_record_s;

endpackage

// ### logic/psl_sampler.sv
// Precise event sampling unit with load latency tagging and an APB register file.
// Notes on behaviour
// - Only counters zero to three take samples.
// - Enable bit 63 gives store capture, counter three.
// - Record address word holds load or store address.
// - Record source word: data source or store status.
// - Record latency word: cycles, or zero for stores.
// - Record clears status of overflowed sampling counters.
// - Only listed event and mask pairs may sample.
// - Exact distribution mask works on counter one only.
// - Latency spans dispatch to writeback, retired demand loads.
// - Count only latencies strictly above threshold register.
// - Hardware tags loads randomly; counts retired tagged.
// - Cancelled tag is dropped; next load gets tagged.
// - Record takes most recent latency and source.
// - Reload value spaces records, independent of tagging.
// - Source word: bits 3:0, 4 miss, 5 lock.
// - Reported IP skids one, two when fused.
// - Overflow arms; next qualifying event triggers record.
// - Failed bounds check skips sample; else store, reload.
// - Buffer full shows in status bit 62.
`timescale 1ns/1ps
`include "psl_regs.svh"

module psl_sampler #(
   parameter int NUM_CTR = 8,
   parameter int NUM_SMP = 4,
   parameter int LAT_W = 16
) (
   // APB slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Core event inputs
   input wire psl_pkg::psl_retire_s retire_in,
   input wire psl_pkg::psl_load_s load_in,
   input wire psl_pkg::psl_store_s store_in,
   // Record output
   output logic rec_strobe,
   output psl_pkg::psl_record_s rec_out
);

   logic [31:0] evsel [NUM_CTR];
   logic [31:0] ctr [NUM_CTR];
   logic [31:0] reload [NUM_SMP];
   logic [31:0] sen_lo;
   logic [31:0] sen_hi;
   logic [LAT_W-1:0] thresh;
   logic [NUM_CTR-1:0] status;
   logic buf_full;
   logic [15:0] buf_idx;
   logic [15:0] buf_lim;
   logic [NUM_CTR-1:0] inc;
   logic [NUM_CTR-1:0] ovf_set;
   logic [NUM_SMP-1:0] armed;
   logic [NUM_SMP-1:0] elig;
   logic [15:0] lfsr;
   logic tag_busy;
   logic tag_next;
   logic lat_done;
   logic [3:0] tag_id;
   logic [LAT_W-1:0] lat_cnt;
   logic [LAT_W-1:0] last_lat;
   logic [5:0] last_src;
   logic [31:0] last_addr;
   logic lat_hit;
   logic lat_mode;
   logic store_cap;
   psl_pkg::psl_state_e state;
   logic [1:0] trig_ctr;
   logic trig;
   logic [1:0] trig_idx;
   logic [1:0] skid_left;
   psl_pkg::psl_record_s pend;
   logic do_store;
   logic acc;
   logic wr_en;
   logic [31:0] rd_data;
   logic rd_err;

   assign acc = psel & penable & pready;
   assign wr_en = acc & pwrite;
   assign store_cap = sen_hi[`PSL_STORE_CAP_BIT];
   assign lat_mode = |sen_hi[NUM_SMP-1:0];
   // bounds check against the buffer limit
   assign do_store = (state == psl_pkg::S_WRITE) && (buf_idx < buf_lim);

   function automatic logic evt_ok(input logic [15:0] s, input int idx);
      logic ok;
      ok = 1'b0;
      case (s[7:0])
         8'hC0: ok = (s == `PSL_EXACT_DIST_EVSEL) && (idx == int'(`PSL_EXACT_DIST_CTR));
         8'hC2: ok = (s[15:8] == 8'h01) || (s[15:8] == 8'h02);
         8'hC4: ok = s[15:8] inside {8'h01, 8'h02, 8'h04, 8'h08, 8'h20};
         8'hC5: ok = s[15:8] inside {8'h01, 8'h02, 8'h04, 8'h10, 8'h20};
         8'hCD: ok = (s == `PSL_LAT_EVSEL) ||
                     ((s == `PSL_STORE_EVSEL) && (idx == int'(`PSL_STORE_CTR)));
         8'hD0: ok = s[15:8] inside {8'h11, 8'h12, 8'h21, 8'h41, 8'h42, 8'h81, 8'h82};
         8'hD1: ok = s[15:8] inside {8'h01, 8'h02, 8'h04, 8'h40};
         8'hD2: ok = s[15:8] inside {8'h01, 8'h02, 8'h04, 8'h08};
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction

   assign lat_hit = load_in.retire && tag_busy && (load_in.ret_id == tag_id) &&
                    load_in.demand && lat_done && (lat_cnt > thresh);

   always_comb begin
      for (int i = 0; i < NUM_CTR; i++) begin
         if (evsel[i][15:0] == `PSL_LAT_EVSEL && i < NUM_SMP && sen_hi[i]) begin
            inc[i] = evsel[i][`PSL_EVSEL_EN_BIT] & lat_hit;
         end else if (evsel[i][15:0] == `PSL_STORE_EVSEL && i == int'(`PSL_STORE_CTR) &&
                      store_cap) begin
            inc[i] = evsel[i][`PSL_EVSEL_EN_BIT] & store_in.retire;
         end else begin
            inc[i] = evsel[i][`PSL_EVSEL_EN_BIT] & retire_in.valid &
                     (retire_in.code == evsel[i][7:0]) &
                     (|(retire_in.umask & evsel[i][15:8]));
         end
         ovf_set[i] = inc[i] & (&ctr[i]);
      end
      for (int i = 0; i < NUM_SMP; i++) begin
         elig[i] = sen_lo[i] & evt_ok(evsel[i][15:0], i);
      end
   end

   // first armed counter with a qualifying event triggers
   always_comb begin
      trig = 1'b0;
      trig_idx = 2'h0;
      for (int i = NUM_SMP - 1; i >= 0; i--) begin
         if (armed[i] && inc[i]) begin
            trig = (state == psl_pkg::S_IDLE);
            trig_idx = 2'(i);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= psel & penable & ~pready;
      end
   end

   always_comb begin
      rd_data = 32'h0000_0000;
      rd_err = 1'b0;
      case (paddr)
         `PSL_OFF_SEN_LO: rd_data = sen_lo;
         `PSL_OFF_SEN_HI: rd_data = sen_hi;
         `PSL_OFF_THRESH: rd_data = 32'(thresh);
         `PSL_OFF_STAT_LO: rd_data = 32'(status);
         // buffer full in upper status word
         `PSL_OFF_STAT_HI: rd_data = 32'(buf_full) << `PSL_BUF_FULL_BIT;
         `PSL_OFF_CLR_LO: rd_data = 32'h0000_0000;
         `PSL_OFF_CLR_HI: rd_data = 32'h0000_0000;
         `PSL_OFF_BUF_IDX: rd_data = 32'(buf_idx);
         `PSL_OFF_BUF_LIM: rd_data = 32'(buf_lim);
         `PSL_OFF_REC_ADDR: rd_data = rec_out.addr;
         `PSL_OFF_REC_SRC: rd_data = 32'(rec_out.src);
         `PSL_OFF_REC_LAT: rd_data = 32'(rec_out.lat);
         `PSL_OFF_REC_IP: rd_data = rec_out.ip;
         default: begin
            rd_err = 1'b1;
            for (int i = 0; i < NUM_CTR; i++) begin
               if (paddr == `PSL_OFF_EVSEL + 8'(4 * i)) begin
                  rd_data = evsel[i];
                  rd_err = 1'b0;
               end
               if (paddr == `PSL_OFF_CTR + 8'(4 * i)) begin
                  rd_data = ctr[i];
                  rd_err = 1'b0;
               end
            end
            for (int i = 0; i < NUM_SMP; i++) begin
               if (paddr == `PSL_OFF_RELOAD + 8'(4 * i)) begin
                  rd_data = reload[i];
                  rd_err = 1'b0;
               end
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel && penable && !pready) begin
         prdata <= pwrite ? 32'h0000_0000 : rd_data;
         pslverr <= rd_err;
      end else begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sen_lo <= 32'h0000_0000;
         sen_hi <= 32'h0000_0000;
         thresh <= LAT_W'(`PSL_THRESH_RST);
         buf_lim <= 16'h0000;
         for (int i = 0; i < NUM_CTR; i++) begin
            evsel[i] <= 32'h0000_0000;
         end
         for (int i = 0; i < NUM_SMP; i++) begin
            reload[i] <= 32'h0000_0000;
         end
      end else if (wr_en) begin
         // only the low counters carry sample enables
         if (paddr == `PSL_OFF_SEN_LO) sen_lo <= pwdata & 32'(2 ** NUM_SMP - 1);
         if (paddr == `PSL_OFF_SEN_HI) begin
            sen_hi <= pwdata & (32'(2 ** NUM_SMP - 1) | (32'h1 << `PSL_STORE_CAP_BIT));
         end
         if (paddr == `PSL_OFF_THRESH) thresh <= pwdata[LAT_W-1:0];
         if (paddr == `PSL_OFF_BUF_LIM) buf_lim <= pwdata[15:0];
         for (int i = 0; i < NUM_CTR; i++) begin
            if (paddr == `PSL_OFF_EVSEL + 8'(4 * i)) evsel[i] <= pwdata;
         end
         for (int i = 0; i < NUM_SMP; i++) begin
            if (paddr == `PSL_OFF_RELOAD + 8'(4 * i)) reload[i] <= pwdata;
         end
      end
   end

   // Counters: software write, then reload after a stored record, then counting.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NUM_CTR; i++) begin
            ctr[i] <= 32'h0000_0000;
         end
      end else begin
         for (int i = 0; i < NUM_CTR; i++) begin
            if (wr_en && paddr == `PSL_OFF_CTR + 8'(4 * i)) begin
               ctr[i] <= pwdata;
            end else if (do_store && i < NUM_SMP && trig_ctr == 2'(i)) begin
               ctr[i] <= reload[i];
            end else if (inc[i]) begin
               ctr[i] <= ctr[i] + 32'h0000_0001;
            end
         end
      end
   end

   // Overflow status; a fresh overflow wins over any clear in the same cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= '0;
         buf_full <= 1'b0;
      end else begin
         for (int i = 0; i < NUM_CTR; i++) begin
            if (ovf_set[i]) begin
               status[i] <= 1'b1;
            end else if (wr_en && paddr == `PSL_OFF_CLR_LO && pwdata[i]) begin
               status[i] <= 1'b0;
            end else if (do_store && i < NUM_SMP && sen_lo[i]) begin
               status[i] <= 1'b0;
            end
         end
         if (do_store && buf_idx + 16'h0001 >= buf_lim) begin
            buf_full <= 1'b1;
         end else if (wr_en && paddr == `PSL_OFF_CLR_HI && pwdata[`PSL_BUF_FULL_BIT]) begin
            buf_full <= 1'b0;
         end
      end
   end

   // arm on overflow of a sampling counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         armed <= '0;
      end else begin
         for (int i = 0; i < NUM_SMP; i++) begin
            if (!elig[i] || (trig && trig_idx == 2'(i))) begin
               armed[i] <= 1'b0;
            end else if (ovf_set[i]) begin
               armed[i] <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lfsr <= `PSL_LFSR_SEED;
      end else begin
         lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      end
   end

   // Load tagging and latency measurement.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tag_busy <= 1'b0;
         tag_next <= 1'b0;
         lat_done <= 1'b0;
         tag_id <= 4'h0;
         lat_cnt <= '0;
      end else if (!tag_busy) begin
         if (lat_mode && load_in.dispatch && (tag_next || lfsr[0])) begin
            tag_busy <= 1'b1;
            tag_next <= 1'b0;
            lat_done <= 1'b0;
            tag_id <= load_in.disp_id;
            lat_cnt <= LAT_W'(1);
         end
      // cancelled tag dropped, next load tagged
      end else if (load_in.cancel && load_in.cancel_id == tag_id) begin
         tag_busy <= 1'b0;
         tag_next <= 1'b1;
      end else if (load_in.retire && load_in.ret_id == tag_id) begin
         tag_busy <= 1'b0;
      end else if (!lat_done) begin
         // count from first dispatch through writeback
         if (!(&lat_cnt)) lat_cnt <= lat_cnt + LAT_W'(1);
         if (load_in.writeback && load_in.wb_id == tag_id) lat_done <= 1'b1;
      end
   end

   // keep the latest qualifying load data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_lat <= '0;
         last_src <= 6'h00;
         last_addr <= 32'h0000_0000;
      end else if (lat_hit) begin
         last_lat <= lat_cnt;
         last_src <= {load_in.lock, load_in.second_level_translation_miss, load_in.src};
         last_addr <= load_in.addr;
      end
   end

   // Record sequencer: trigger, instruction skid, then bounds check and store.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= psl_pkg::S_IDLE;
         trig_ctr <= 2'h0;
         skid_left <= 2'h0;
         pend <= '0;
         buf_idx <= 16'h0000;
         rec_strobe <= 1'b0;
         rec_out <= '0;
      end else begin
         rec_strobe <= 1'b0;
         if (wr_en && paddr == `PSL_OFF_BUF_IDX) buf_idx <= pwdata[15:0];
         case (state)
            psl_pkg::S_IDLE: begin
               if (trig) begin
                  trig_ctr <= trig_idx;
                  // skid of one, two when fused
                  skid_left <= (retire_in.valid && retire_in.fused) ? 2'h2 : 2'h1;
                  pend.ctr <= trig_idx;
                  if (store_cap && trig_idx == 2'(`PSL_STORE_CTR)) begin
                     pend.addr <= store_in.addr;
                     pend.src <= {store_in.lock, store_in.second_level_translation_miss, 3'h0, store_in.l1_hit};
                     pend.lat <= 16'h0000;
                  end else begin
                     pend.addr <= lat_hit ? load_in.addr : last_addr;
                     pend.src <= lat_hit ? {load_in.lock, load_in.second_level_translation_miss, load_in.src}
                                         : last_src;
                     pend.lat <= 16'(lat_hit ? lat_cnt : last_lat);
                  end
                  state <= psl_pkg::S_SKID;
               end
            end
            psl_pkg::S_SKID: begin
               if (retire_in.valid) begin
                  skid_left <= skid_left - 2'h1;
                  if (skid_left == 2'h1) begin
                     pend.ip <= retire_in.ip;
                     state <= psl_pkg::S_WRITE;
                  end
               end
            end
            psl_pkg::S_WRITE: begin
               // store only when inside the buffer
               if (do_store) begin
                  rec_out <= pend;
                  rec_strobe <= 1'b1;
                  buf_idx <= buf_idx + 16'h0001;
               end
               state <= psl_pkg::S_IDLE;
            end
            default: state <= psl_pkg::S_IDLE;
         endcase
      end
   end

endmodule

// ### tb/psl_sampler_props.sv
// Concurrent property checker for the precise sampling block, bound to its top module.
`timescale 1ns/1ps
module psl_sampler_props (
   // APB side
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Core events
   input wire psl_pkg::psl_retire_s retire_in,
   input wire psl_pkg::psl_load_s load_in,
   input wire psl_pkg::psl_store_s store_in,
   // Records
   input wire logic rec_strobe,
   input wire psl_pkg::psl_record_s rec_out
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence apb_setup;
      psel && !penable;
   endsequence
   sequence apb_wait;
      psel && penable && !pready;
   endsequence

   apb_one_wait_a:
      assert property (apb_setup |=> apb_wait ##1 pready)
      else $error("pready not on the second access cycle");
   ready_pulse_a:
      assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   ready_in_access_a:
      assert property (pready |-> psel && penable && $past(penable))
      else $error("pready outside the access phase");
   err_with_ready_a:
      assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   rdata_idle_a:
      assert property (!(pready && !pwrite) |-> prdata == 32'h0)
      else $error("prdata not zero outside a read answer");
   record_pulse_a:
      assert property (rec_strobe |=> !rec_strobe)
      else $error("record strobe longer than one cycle");
   skid_retire_a:
      assert property (rec_strobe |-> $past(retire_in.valid, 2) &&
                       rec_out.ip == $past(retire_in.ip, 2))
      else $error("record ip not taken from the skid retirement");
   record_hold_a:
      assert property (!rec_strobe |-> rec_out == $past(rec_out))
      else $error("record changed without a strobe");
endmodule

bind psl_sampler psl_sampler_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .retire_in(retire_in), .load_in(load_in),
   .store_in(store_in), .rec_strobe(rec_strobe), .rec_out(rec_out));

// ### tb/psl_sampler_tb.sv
// Self-checking bench for the precise sampling block.
`timescale 1ns/1ps
`include "psl_regs.svh"
module psl_sampler_tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rec_strobe, e;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   psl_pkg::psl_retire_s retire_in;
   psl_pkg::psl_load_s load_in;
   psl_pkg::psl_store_s store_in;
   psl_pkg::psl_record_s rec_out;
   int num_errors, num_checks, num_recs;
   // Every eligible pair except 01CD and 02CD as {mask, code}; the first one is counter one only.
   logic [15:0] pairs [28] = '{16'h01C0, 16'h01C2, 16'h02C2, 16'h01C4, 16'h02C4, 16'h04C4,
      16'h08C4, 16'h20C4, 16'h01C5, 16'h02C5, 16'h04C5, 16'h10C5, 16'h20C5, 16'h11D0,
      16'h12D0, 16'h21D0, 16'h41D0, 16'h42D0, 16'h81D0, 16'h82D0, 16'h01D1, 16'h02D1,
      16'h04D1, 16'h40D1, 16'h01D2, 16'h02D2, 16'h04D2, 16'h08D2};

   psl_sampler i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .retire_in(retire_in), .load_in(load_in), .store_in(store_in),
      .rec_strobe(rec_strobe), .rec_out(rec_out));

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      if (rec_strobe === 1'b1) num_recs++;
   end

   task automatic conclude;
      if (num_errors == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic check(input string n, input logic [31:0] s, input logic [31:0] x);
      num_checks++;
      if (s !== x) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", n, x, s);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         num_errors++;
         conclude();
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input string n, input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      check(n, q, x);
   endtask

   task automatic ret(input logic [7:0] c, input logic [7:0] m, input logic [31:0] ip,
         input logic f);
      @(posedge pclk);
      retire_in <= '{1'b1, c, m, ip, f};
      @(posedge pclk);
      retire_in.valid <= 1'b0;
   endtask

   task automatic st;
      @(posedge pclk);
      store_in.retire <= 1'b1;
      @(posedge pclk);
      store_in.retire <= 1'b0;
   endtask

   // Load whose dispatch-to-writeback span is six cycles, or cancelled after dispatch.
   task automatic ld(input logic [3:0] id, input logic cx);
      @(posedge pclk);
      load_in.dispatch <= 1'b1;
      load_in.disp_id <= id;
      @(posedge pclk);
      load_in.dispatch <= 1'b0;
      load_in.cancel <= cx;
      load_in.cancel_id <= id;
      @(posedge pclk);
      load_in.cancel <= 1'b0;
      repeat (3) @(posedge pclk);
      load_in.writeback <= !cx;
      load_in.wb_id <= id;
      @(posedge pclk);
      load_in.writeback <= 1'b0;
      load_in.retire <= !cx;
      load_in.ret_id <= id;
      @(posedge pclk);
      load_in.retire <= 1'b0;
   endtask

   task automatic wait_rec(input int n);
      int k;
      k = 0;
      while (num_recs < n && k < 20) begin
         @(posedge pclk);
         k++;
      end
      if (num_recs < n) begin
         num_errors++;
         conclude();
      end
   endtask

   // Overflow, trigger and skid on one counter, then switch the counter off.
   task automatic smp(input int c, input logic [15:0] p, input logic f, input logic [31:0] ip);
      wr(`PSL_OFF_CTR + 8'(4 * c), 32'hFFFF_FFFF);
      wr(`PSL_OFF_EVSEL + 8'(4 * c), {16'h0040, p});
      ret(p[7:0], p[15:8], 32'h0, 1'b0);
      ret(p[7:0], p[15:8], 32'h0, f);
      ret(8'h00, 8'h00, ip, 1'b0);
      if (f) ret(8'h00, 8'h00, ip + 32'h1, 1'b0);
      wr(`PSL_OFF_EVSEL + 8'(4 * c), 32'h0);
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      retire_in = '0;
      load_in = '0;
      store_in = '0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd("threshold reset", `PSL_OFF_THRESH, 32'h3);
      rd("status reset", `PSL_OFF_STAT_LO, 32'h0);
      apb(1'b0, 8'h84, 32'h0);
      check("unmapped error", {31'h0, e}, 32'h1);
      check("unmapped data", q, 32'h0);
      wr(`PSL_OFF_BUF_LIM, 32'h64);
      wr(`PSL_OFF_RELOAD, 32'h5);
      wr(`PSL_OFF_SEN_LO, 32'h13);
      rd("sample enables", `PSL_OFF_SEN_LO, 32'h3);
      wr(`PSL_OFF_EVSEL + 8'h10, 32'h0040_01C2);
      wr(`PSL_OFF_CTR + 8'h10, 32'hFFFF_FFFF);
      for (int i = 0; i < 28; i++) begin
         smp(i == 0, pairs[i], i == 1, 32'h100 + i);
         wait_rec(i + 1);
         check("record ip", rec_out.ip, 32'h100 + i + (i == 1));
         check("record counter", 32'(rec_out.ctr), 32'(i == 0));
      end
      rd("reloaded counter", `PSL_OFF_CTR, 32'h5);
      rd("status kept", `PSL_OFF_STAT_LO, 32'h10);
      rd("buffer index", `PSL_OFF_BUF_IDX, 32'd28);
      wr(`PSL_OFF_EVSEL + 8'h10, 32'h0);
      wr(`PSL_OFF_SEN_LO, 32'h4);
      smp(2, 16'h013C, 1'b0, 32'h0);
      smp(2, 16'h01C0, 1'b0, 32'h0);
      repeat (6) @(posedge pclk);
      check("ineligible records", num_recs, 32'd28);
      rd("status ineligible", `PSL_OFF_STAT_LO, 32'h14);
      wr(`PSL_OFF_CLR_LO, 32'h14);
      rd("status cleared", `PSL_OFF_STAT_LO, 32'h0);
      wr(`PSL_OFF_BUF_IDX, 32'h0);
      wr(`PSL_OFF_BUF_LIM, 32'h1);
      wr(`PSL_OFF_SEN_LO, 32'h1);
      smp(0, 16'h01C2, 1'b0, 32'h7);
      wait_rec(29);
      rd("buffer full", `PSL_OFF_STAT_HI, 32'h4000_0000);
      smp(0, 16'h01C2, 1'b0, 32'h8);
      repeat (6) @(posedge pclk);
      check("skipped sample", num_recs, 32'd29);
      rd("index held", `PSL_OFF_BUF_IDX, 32'h1);
      wr(`PSL_OFF_CLR_HI, 32'h4000_0000);
      rd("full cleared", `PSL_OFF_STAT_HI, 32'h0);
      wr(`PSL_OFF_BUF_LIM, 32'h64);
      wr(`PSL_OFF_SEN_HI, 32'h1);
      wr(`PSL_OFF_CTR, 32'hFFFF_FFFF);
      wr(`PSL_OFF_EVSEL, 32'h0040_01CD);
      load_in.demand <= 1'b1;
      load_in.addr <= 32'hA5A5_0040;
      load_in.src <= 4'hA;
      load_in.second_level_translation_miss <= 1'b1;
      load_in.lock <= 1'b0;
      for (int i = 0; i < 80 && num_recs < 30; i++) begin
         ld(4'(i), 1'b0);
         ret(8'h00, 8'h00, 32'h200, 1'b0);
      end
      wait_rec(30);
      check("load address", rec_out.addr, 32'hA5A5_0040);
      check("load source", 32'(rec_out.src), 32'h1A);
      check("load latency", 32'(rec_out.lat), 32'h6);
      rd("source word", `PSL_OFF_REC_SRC, 32'h1A);
      wr(`PSL_OFF_CTR, 32'h0);
      for (int m = 0; m < 3; m++) begin
         wr(`PSL_OFF_THRESH, (m == 0) ? 32'h6 : 32'h3);
         load_in.demand <= (m != 2);
         for (int i = 0; i < 8; i++) ld(4'(i), m == 1);
      end
      rd("uncounted loads", `PSL_OFF_CTR, 32'h0);
      wr(`PSL_OFF_EVSEL, 32'h0);
      wr(`PSL_OFF_SEN_LO, 32'h8);
      wr(`PSL_OFF_SEN_HI, 32'h8000_0000);
      store_in <= '{1'b0, 32'h0000_BEE0, 1'b1, 1'b1, 1'b1};
      for (int c = 3; c > 1; c--) begin
         wr(`PSL_OFF_CTR + 8'(4 * c), 32'hFFFF_FFFF);
         wr(`PSL_OFF_EVSEL + 8'(4 * c), 32'h0040_02CD);
         st();
         st();
         ret(8'h00, 8'h00, 32'h300, 1'b0);
         wr(`PSL_OFF_EVSEL + 8'(4 * c), 32'h0);
         wr(`PSL_OFF_SEN_LO, 32'h4);
      end
      check("store records", num_recs, 32'd31);
      check("store counter", 32'(rec_out.ctr), 32'h3);
      check("store address", rec_out.addr, 32'h0000_BEE0);
      check("store status", 32'(rec_out.src), 32'h31);
      check("store latency", 32'(rec_out.lat), 32'h0);
      conclude();
   end
endmodule
